// *** include/difd_pkg.sv ***
// package for the digital input function decoder
package difd_pkg;
    localparam int DIFD_NUM_DI = 8;
    localparam logic [7:0] FC_SERVO_ENABLE = 8'h01;
    localparam logic [7:0] FC_FAULT_CLEAR = 8'h02;
    localparam logic [7:0] FC_GAIN_BOOST = 8'h03;
    localparam logic [7:0] FC_COUNT_CLEAR = 8'h04;
    localparam logic [7:0] FC_ZERO_HOLD = 8'h05;
    localparam logic [7:0] FC_CMD_REVERSE = 8'h06;
    localparam logic [7:0] FC_TORQUE_CAP = 8'h09;
    localparam logic [7:0] FC_SPEED_CAP = 8'h10;
    // register byte addresses
    localparam logic [7:0] ADDR_FUNC_LO = 8'h00;
    localparam logic [7:0] ADDR_FUNC_HI = 8'h04;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_SPEED = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_INPUTS = 8'h14;
    // config fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_GAIN_LSB = 4;
    localparam int CFG_CLRTRIG_BIT = 8;
    localparam int CFG_ZSPD_LSB = 16;
    // control mode codes
    localparam logic [1:0] MODE_POSITION = 2'h0;
    localparam logic [1:0] MODE_SPEED = 2'h1;
    localparam logic [1:0] MODE_TORQUE = 2'h2;
    localparam logic [1:0] MODE_OTHER = 2'h3;
    localparam logic [3:0] GAIN_SWITCH_DI = 4'h1;
    localparam logic [31:0] FUNC_RESET = 32'h0;
    localparam logic [31:0] CONFIG_RESET = 32'h0;
endpackage

// *** hdl/difd_decoder.sv ***
// digital input function decoder with wishbone register access
//
// Behaviour
// - code 0x01 input held high keeps servo enabled, any mode.
// - code 0x02 rising edge clears pending alarm once cause is gone.
// - code 0x03 high, position/speed mode, gain switch 1: boost gain.
// - code 0x04 in position mode clears pulse counter, edge or level.
// - code 0x05 high in speed mode below zero threshold stops motor.
// - code 0x06 high in speed or torque mode reverses command.
// - code 0x09 high in position or speed mode caps torque.
// - code 0x10 high in torque mode caps speed.
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module difd_decoder
    import difd_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] di_pin_i,
    input wire logic alarm_cause_i,
    input wire logic [15:0] speed_meas_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic servo_enable_o,
    output logic alarm_pending_o,
    output logic gain_boost_o,
    output logic pulse_count_clear_o,
    output logic zero_speed_hold_o,
    output logic command_reverse_o,
    output logic torque_cap_o,
    output logic speed_cap_o
);
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] di_level;
    logic [7:0] di_prev;
    logic [31:0] func_lo;
    logic [31:0] func_hi;
    logic [31:0] config_reg;
    logic alarm_cause_q;
    logic [7:0] hit_servo;
    logic [7:0] hit_fault;
    logic [7:0] hit_gain;
    logic [7:0] hit_clr_lvl;
    logic [7:0] hit_clr_edge;
    logic [7:0] hit_zero;
    logic [7:0] hit_rev;
    logic [7:0] hit_tcap;
    logic [7:0] hit_scap;
    logic [1:0] mode;
    logic [3:0] gain_switch_config;
    logic count_clear_trigger_config;
    logic [15:0] zero_speed_threshold;
    logic wb_req;
    logic wb_wr;
    logic [31:0] next_rdata;

    assign mode = config_reg[CFG_MODE_LSB +: 2];
    assign gain_switch_config = config_reg[CFG_GAIN_LSB +: 4];
    assign count_clear_trigger_config = config_reg[CFG_CLRTRIG_BIT];
    assign zero_speed_threshold = config_reg[CFG_ZSPD_LSB +: 16];

    // function code assigned to input n
    function automatic logic [7:0] code_of(input logic [31:0] lo, input logic [31:0] hi,
        input int n);
        logic [63:0] all;
        all = {hi, lo};
        return all[n*8 +: 8];
    endfunction

    // true when the active mode is among those an action may run in
    function automatic logic mode_ok(input logic [1:0] m, input logic in_pos,
        input logic in_spd, input logic in_trq);
        logic ok;
        case (m)
            MODE_POSITION: ok = in_pos;
            MODE_SPEED: ok = in_spd;
            MODE_TORQUE: ok = in_trq;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // three-stage input synchroniser; only the second stage reads the first
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
            sync3 <= 8'h00;
        end
        else
        begin
            sync1 <= di_pin_i;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // filtered level: a change counts once stages two and three agree
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            di_level <= 8'h00;
        else
            di_level <= (sync2 & sync3) | (di_level & (sync2 | sync3));
    end

    // previous filtered level, for rising-edge detection
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            di_prev <= 8'h00;
        else
            di_prev <= di_level;
    end

    // per-input decode; only listed codes match anything
    genvar g;
    generate
        for (g = 0; g < DIFD_NUM_DI; g++)
        begin : g_di
            logic [7:0] c;
            logic rise;
            assign c = code_of(func_lo, func_hi, g);
            assign rise = di_level[g] & ~di_prev[g];
            assign hit_servo[g] = (c == FC_SERVO_ENABLE) & di_level[g];
            assign hit_fault[g] = (c == FC_FAULT_CLEAR) & rise;
            assign hit_gain[g] = (c == FC_GAIN_BOOST) & di_level[g];
            assign hit_clr_lvl[g] = (c == FC_COUNT_CLEAR) & di_level[g];
            assign hit_clr_edge[g] = (c == FC_COUNT_CLEAR) & rise;
            assign hit_zero[g] = (c == FC_ZERO_HOLD) & di_level[g];
            assign hit_rev[g] = (c == FC_CMD_REVERSE) & di_level[g];
            assign hit_tcap[g] = (c == FC_TORQUE_CAP) & di_level[g];
            assign hit_scap[g] = (c == FC_SPEED_CAP) & di_level[g];
        end
    endgenerate

    // servo enable follows any code 0x01 input, in every mode
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            servo_enable_o <= 1'b0;
        else
            servo_enable_o <= |hit_servo;
    end

    // gain boost in position or speed mode with the gain switch set to 1
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            gain_boost_o <= 1'b0;
        else
            gain_boost_o <= (|hit_gain) && mode_ok(mode, 1'b1, 1'b1, 1'b0)
                && gain_switch_config == GAIN_SWITCH_DI;
    end

    // pulse counter clear in position mode, by level or by rising edge
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            pulse_count_clear_o <= 1'b0;
        else
            pulse_count_clear_o <= mode_ok(mode, 1'b1, 1'b0, 1'b0)
                && (count_clear_trigger_config ? (|hit_clr_lvl)
                : (|hit_clr_edge));
    end

    // zero-speed hold in speed mode below the threshold
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            zero_speed_hold_o <= 1'b0;
        else
            zero_speed_hold_o <= (|hit_zero) && mode_ok(mode, 1'b0, 1'b1, 1'b0)
                && speed_meas_i < zero_speed_threshold;
    end

    // command reversal in speed or torque mode
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            command_reverse_o <= 1'b0;
        else
            command_reverse_o <= (|hit_rev)
                && mode_ok(mode, 1'b0, 1'b1, 1'b1);
    end

    // torque cap in position or speed mode
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            torque_cap_o <= 1'b0;
        else
            torque_cap_o <= (|hit_tcap)
                && mode_ok(mode, 1'b1, 1'b1, 1'b0);
    end

    // speed cap in torque mode
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            speed_cap_o <= 1'b0;
        else
            speed_cap_o <= (|hit_scap)
                && mode_ok(mode, 1'b0, 1'b0, 1'b1);
    end

    // registered copy of the alarm cause
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            alarm_cause_q <= 1'b0;
        else
            alarm_cause_q <= alarm_cause_i;
    end

    // alarm: latched by cause, cleared by fault-clear edge once cause gone; cause wins
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            alarm_pending_o <= 1'b0;
        else if (alarm_cause_q)
            alarm_pending_o <= 1'b1;
        else if (|hit_fault)
            alarm_pending_o <= 1'b0;
    end

    // wishbone slave, ack one cycle after request
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // a write lands at the edge where the master sees ack, while the request still stands
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & (wb_adr_i[31:8] == 24'h00_0000);

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_req;
    end

    // read data stands only in the ack cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            wb_dat_o <= 32'h0000_0000;
        else
            wb_dat_o <= wb_req ? next_rdata : 32'h0000_0000;
    end

    always_comb
    begin
        unique case (wb_adr_i[7:0])
            ADDR_FUNC_LO: next_rdata = func_lo;
            ADDR_FUNC_HI: next_rdata = func_hi;
            ADDR_CONFIG: next_rdata = config_reg;
            ADDR_SPEED: next_rdata = {16'h0000, speed_meas_i};
            ADDR_STATUS: next_rdata = {24'h00_0000, speed_cap_o, torque_cap_o,
                command_reverse_o, zero_speed_hold_o, pulse_count_clear_o, gain_boost_o,
                alarm_pending_o, servo_enable_o};
            ADDR_INPUTS: next_rdata = {24'h00_0000, di_level};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // function codes of inputs 0 to 3, byte enables honoured
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            func_lo <= FUNC_RESET;
        else if (wb_wr && wb_adr_i[7:0] == ADDR_FUNC_LO)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (wb_sel_i[b])
                    func_lo[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
        end
    end

    // function codes of inputs 4 to 7, byte enables honoured
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            func_hi <= FUNC_RESET;
        else if (wb_wr && wb_adr_i[7:0] == ADDR_FUNC_HI)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (wb_sel_i[b])
                    func_hi[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
        end
    end

    // mode, gain switch, clear trigger and zero-speed threshold
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            config_reg <= CONFIG_RESET;
        else if (wb_wr && wb_adr_i[7:0] == ADDR_CONFIG)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (wb_sel_i[b])
                    config_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
        end
    end
endmodule // difd_decoder

// *** sim/difd_checker.sv ***
// port checker for the input function decoder
`timescale 1ns/1ps
module difd_checker
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] di_pin_i,
    input wire logic alarm_cause_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic servo_enable_o,
    input wire logic alarm_pending_o,
    input wire logic gain_boost_o,
    input wire logic pulse_count_clear_o,
    input wire logic zero_speed_hold_o,
    input wire logic command_reverse_o,
    input wire logic torque_cap_o,
    input wire logic speed_cap_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    wire idle = di_pin_i == 8'h00;
    AST_SERVO_IDLE:
    assert property (idle [*7] |=> !servo_enable_o) else $error("servo on, inputs low");
    AST_ALARM_SET:
    assert property (alarm_cause_i [*3] |=> alarm_pending_o) else $error("alarm not set");
    AST_ALARM_KEEP:
    assert property ($fell(alarm_pending_o) && $past(reset_n_i) |-> !$past(alarm_cause_i, 2))
        else $error("alarm cleared with cause");
    AST_SCAP_MODE:
    assert property (speed_cap_o |-> !(torque_cap_o || gain_boost_o || zero_speed_hold_o))
        else $error("speed cap outside torque mode");
    AST_REV_MODE:
    assert property (command_reverse_o |-> !pulse_count_clear_o) else $error("reverse in pos");
    AST_LEVEL_IDLE:
    assert property (idle [*8] |=> !(gain_boost_o || pulse_count_clear_o || zero_speed_hold_o
        || command_reverse_o)) else $error("action with inputs low");
    AST_CAP_IDLE:
    assert property (idle [*7] |=> !torque_cap_o && !speed_cap_o) else $error("cap, inputs low");
    AST_ACK_TIME:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    cover property ($rose(servo_enable_o));
    cover property (pulse_count_clear_o);
    cover property ($fell(alarm_pending_o));
endmodule // difd_checker
bind difd_decoder difd_checker CHK (.*);

// *** sim/difd_ctrl_model.sv ***
// controller model driving the digital input lines
`timescale 1ns/1ps
module difd_ctrl_model
(
    input wire logic ref_clk_i,
    input wire logic [7:0] level_i,
    output logic [7:0] di_pin_o
);
    initial di_pin_o = 8'h00;
    always @(posedge ref_clk_i) di_pin_o <= level_i;
endmodule // difd_ctrl_model

// *** sim/tb_top.sv ***
// self-checking bench for the input function decoder
`timescale 1ns/1ps
module tb_top;
    import difd_pkg::*;
    logic ref_clk_i = 0, reset_n_i = 0, alarm_cause_i = 0, wb_we_i = 0, wb_cyc_i = 0;
    logic wb_stb_i = 0, wb_ack_o;
    logic [7:0] di_level = 8'h00, di_pin, act, e;
    logic [15:0] speed_meas_i = 16'h0000;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd, cfg;
    logic [7:0] code [8];
    logic [7:0] codes [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
        8'h09, 8'h10};
    int err_count = 0, num_checks = 0, seed = 32'h2bf2, pc = 0, m, g;
    always #4 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) pc <= pc + act[3];
    difd_ctrl_model CTRL (.ref_clk_i(ref_clk_i), .level_i(di_level), .di_pin_o(di_pin));
    difd_decoder DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .di_pin_i(di_pin),
        .alarm_cause_i(alarm_cause_i), .speed_meas_i(speed_meas_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .servo_enable_o(act[0]), .alarm_pending_o(act[1]), .gain_boost_o(act[2]),
        .pulse_count_clear_o(act[3]), .zero_speed_hold_o(act[4]),
        .command_reverse_o(act[5]), .torque_cap_o(act[6]), .speed_cap_o(act[7]));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge ref_clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= {24'h0, adr};
        wb_dat_i <= dat;
        do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk_i);
        reset_n_i <= 1;
        wb(0, ADDR_CONFIG, 0);
        check(rd, CONFIG_RESET);
        wb(0, 8'h18, 0);
        check(rd, 32'h0);
        wb(1, ADDR_FUNC_LO, 32'h0402);
        alarm_cause_i <= 1;
        repeat (4) @(posedge ref_clk_i);
        alarm_cause_i <= 0;
        repeat (8) @(posedge ref_clk_i);
        check(act, 8'h02);
        g = pc;
        di_level <= 8'h03;
        repeat (10) @(posedge ref_clk_i);
        check(act, 8'h00);
        check(pc - g, 1);
        for (int k = 0; k < 60; k++)
        begin
            foreach (code[n]) code[n] = codes[$unsigned($random(seed)) % 11];
            m = $unsigned($random(seed)) % 4;
            g = $unsigned($random(seed)) % 3;
            cfg = ($random(seed) << 16) | 32'h100 | (g << 4) | m;
            wb(1, ADDR_FUNC_LO, {code[3], code[2], code[1], code[0]});
            wb(1, ADDR_FUNC_HI, {code[7], code[6], code[5], code[4]});
            wb(1, ADDR_CONFIG, cfg);
            speed_meas_i <= 16'($random(seed));
            di_level <= 8'($random(seed));
            repeat (8) @(posedge ref_clk_i);
            e = 8'h00;
            foreach (code[n])
                if (di_pin[n])
                begin
                    e[0] |= code[n] == FC_SERVO_ENABLE;
                    e[2] |= code[n] == FC_GAIN_BOOST && m < 2 && g == 1;
                    e[3] |= code[n] == FC_COUNT_CLEAR && m == 0;
                    e[4] |= code[n] == FC_ZERO_HOLD && m == 1 && speed_meas_i < cfg[31:16];
                    e[5] |= code[n] == FC_CMD_REVERSE && (m == 1 || m == 2);
                    e[6] |= code[n] == FC_TORQUE_CAP && m < 2;
                    e[7] |= code[n] == FC_SPEED_CAP && m == 2;
                end
            check(act & 8'hFD, e);
        end
        wb(0, ADDR_CONFIG, 0);
        check(rd, cfg);
        wb(0, ADDR_STATUS, 0);
        check(rd, {24'h00_0000, e});
        wb(0, ADDR_FUNC_HI, 0);
        check(rd, {code[7], code[6], code[5], code[4]});
        wb(0, ADDR_SPEED, 0);
        check(rd, {16'h0000, speed_meas_i});
        wb(0, ADDR_INPUTS, 0);
        check(rd, {24'h00_0000, di_pin});
        reset_n_i <= 0;
        repeat (2) @(posedge ref_clk_i);
        check(act, 8'h00);
        reset_n_i <= 1;
        wb(0, ADDR_FUNC_LO, 0);
        check(rd, FUNC_RESET);
        final_report();
    end
    initial
    begin
        #200000;
        err_count++;
        final_report();
    end
endmodule // tb_top
